// [hw/sblp_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - In a write the device, as master, drives data lines with the write data.
// - In a read the addressed slave drives data; the device only samples.
// - Data lines 61-63 carry data only in the full-width bus-only setup.
// - The agent driving data also drives the parity lanes for that beat.
// - Each lane plus its byte holds an odd count of ones; lane 0 is bits 0-7.
// - Lanes 1, 2, 3 cover bits 8-15, 16-23, 24-31 with odd parity.
// - Lanes 4 to 7 cover bits 32-39 up to 56-63 with odd parity.
// - The arbiter raises the matching address bus grant to that master.
// - The arbiter raises a separate data bus grant to an external master.
// - Drive busy for whole data tenure, release after ack, yield to others.
// - Eight external interrupt inputs forward requests to the core.
// - With host port on, it is selected when either chip select is active.
// - With host port on, a width input picks 8-bit or 16-bit transfers.
// - With host port on, an input sets the data strobe active polarity.
// - With host port on, an input picks single or dual strobe operation.
// - Single request setup uses acknowledge with programmable polarity.
// - Double request setup drives receive request, polarity and drive set.
// - Pins taken by the host port lose their normal bus function.
// - Host port off: low 32 lines join 64-bit bus; on: 32-bit bus.
module sblp_top
	import sblp_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	// Clock, reset, enable
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 ce_in,
	// Configuration
	input  wire logic                 host_port_en_in,
	input  wire logic                 bus_only_mode_in,
	input  wire sblp_host_cfg_t       host_cfg_in,
	// Internal master write stream and read start
	input  wire logic                 wr_valid_in,
	output logic                      wr_ready_out,
	input  wire logic [DATA_W-1:0]    wr_data_in,
	input  wire logic                 rd_start_in,
	// Read data stream
	output logic                      rd_valid_out,
	output logic      [DATA_W-1:0]    rd_data_out,
	output logic                      parity_err_out,
	// Data bus pins
	input  wire sblp_beat_t           bus_in,
	output sblp_beat_t                bus_out,
	output logic      [DATA_W-1:0]    data_oe_out,
	output logic      [LANES-1:0]     parity_oe_out,
	input  wire logic                 xfer_ack_in,
	// Data tenure busy pin
	input  wire logic                 data_tenure_busy_in,
	output logic                      data_tenure_busy_out,
	output logic                      data_tenure_busy_oe_out,
	// Arbitration pins
	input  wire logic [REQ_N-1:0]     ext_bus_request_in,
	output logic      [REQ_N-1:0]     ext_bus_grant_out,
	output logic      [REQ_N-1:0]     ext_data_bus_grant_out,
	// Interrupts
	input  wire logic [IRQ_N-1:0]     ext_interrupt_request_line_in,
	output logic      [IRQ_N-1:0]     core_irq_out,
	// Host port status and control
	output logic                      host_selected_out,
	output logic                      host_width8_out,
	output logic                      host_strobe_active_out,
	output logic                      host_dual_strobe_out,
	input  wire logic                 host_strobe_in,
	input  wire logic                 host_acknowledge_in,
	output logic                      host_ack_seen_out,
	input  wire logic                 rx_request_in,
	output logic                      host_receive_request_out,
	output logic                      host_receive_request_oe_out
);

	// ****************************************************
	// Helpers
	// ****************************************************
	function automatic logic [LANES-1:0] odd_par(input logic [DATA_W-1:0] d);
		logic [LANES-1:0] p;
		p = '0;
		for (int i = 0; i < LANES; i++)
			p[i] = ~^d[i*BYTE_W +: BYTE_W];
		return p;
	endfunction : odd_par

	function automatic logic [DATA_W-1:0] lane_mask(input logic hp,
	                                                 input logic bo);
		logic [DATA_W-1:0] m;
		m = '1;
		if (hp)
			m[DATA_W-1:NARROW_W] = '0;
		if (!bo)
			m[TOP_BITS_LSB +: TOP_BITS_N] = '0;
		return m;
	endfunction : lane_mask

	// ****************************************************
	// Write FIFO
	// ****************************************************
	// Buffering decouples the core from arbitration latency
	logic              fifo_valid;
	logic              fifo_pop;
	logic [WIDTH-1:0]  fifo_data;
	sblp_state_t       state;
	logic [DATA_W-1:0] mask;
	logic [DATA_W-1:0] drive_word;
	logic              take_bus;
	logic [LANES-1:0]  lane_used;
	logic              ext_busy;

	sblp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.ce_in         (ce_in),
		.in_valid_in   (wr_valid_in),
		.in_ready_out  (wr_ready_out),
		.in_data_in    (wr_data_in),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop),
		.out_data_out  (fifo_data)
	);

	assign mask     = lane_mask(host_port_en_in, bus_only_mode_in);
	assign ext_busy = data_tenure_busy_in || (ext_data_bus_grant_out != '0);
	assign fifo_pop = (state == SBLP_WRITE) && xfer_ack_in;
	assign drive_word = fifo_valid ? (fifo_data & mask) : '0;
	assign take_bus = !ext_busy && (fifo_valid || rd_start_in);
	always_comb
	begin
		for (int i = 0; i < LANES; i++)
			lane_used[i] = mask[i*BYTE_W];
	end

	// ****************************************************
	// Data tenure state
	// ****************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			state <= SBLP_IDLE;
		else if (ce_in)
		begin
			case (state)
				SBLP_IDLE:
					if (!ext_busy && fifo_valid)
						state <= SBLP_WRITE;
					else if (!ext_busy && rd_start_in)
						state <= SBLP_READ;
					else if (ext_bus_request_in != '0)
						state <= SBLP_EXT;
				SBLP_WRITE, SBLP_READ:
					if (xfer_ack_in)
						state <= SBLP_IDLE;
				SBLP_EXT:
					if (ext_bus_request_in == '0 && !data_tenure_busy_in)
						state <= SBLP_IDLE;
				default:
					state <= SBLP_IDLE;
			endcase
		end
	end

	// Pins are driven from one cycle into the tenure and held through the cycle of the ack that closes the beat
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			bus_out       <= '{data: '0, parity: '1};
			data_oe_out   <= '0;
			parity_oe_out <= '0;
		end
		else if (ce_in)
		begin
			bus_out.data   <= drive_word;
			bus_out.parity <= odd_par(drive_word);
			if (state == SBLP_WRITE && !xfer_ack_in)
			begin
				data_oe_out   <= mask;
				parity_oe_out <= lane_used;
			end
			else
			begin
				data_oe_out   <= '0;
				parity_oe_out <= PAR_NONE;
			end
		end
	end

	// Busy is driven low one cycle after ack, then released
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			data_tenure_busy_out    <= 1'b0;
			data_tenure_busy_oe_out <= 1'b0;
		end
		else if (ce_in)
		begin
			data_tenure_busy_out <= (state == SBLP_WRITE ||
			                         state == SBLP_READ) && !xfer_ack_in;
			data_tenure_busy_oe_out <= (state == SBLP_WRITE ||
			                            state == SBLP_READ);
		end
	end

	// ****************************************************
	// Read capture and parity check
	// ****************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			rd_valid_out   <= 1'b0;
			rd_data_out    <= '0;
			parity_err_out <= 1'b0;
		end
		else if (ce_in)
		begin
			rd_valid_out   <= (state == SBLP_READ) && xfer_ack_in;
			rd_data_out    <= bus_in.data & mask;
			parity_err_out <= (state == SBLP_READ) && xfer_ack_in &&
			                  ((odd_par(bus_in.data) ^ bus_in.parity)
			                   & lane_used) != '0;
		end
	end

	// ****************************************************
	// Arbiter
	// ****************************************************
	// Fixed priority: request a beats request b
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			ext_bus_grant_out      <= '0;
			ext_data_bus_grant_out <= '0;
		end
		else if (ce_in)
		begin
			ext_bus_grant_out      <= '0;
			ext_data_bus_grant_out <= '0;
			if ((state == SBLP_IDLE && !take_bus) || state == SBLP_EXT)
			begin
				if (ext_bus_request_in[0])
				begin
					ext_bus_grant_out[0]      <= 1'b1;
					ext_data_bus_grant_out[0] <= 1'b1;
				end
				else if (ext_bus_request_in[1])
				begin
					ext_bus_grant_out[1]      <= 1'b1;
					ext_data_bus_grant_out[1] <= 1'b1;
				end
			end
		end
	end

	// ****************************************************
	// Interrupts and host port
	// ****************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			core_irq_out <= '0;
		else if (ce_in)
			core_irq_out <= ~ext_interrupt_request_line_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			host_selected_out           <= 1'b0;
			host_width8_out             <= 1'b0;
			host_strobe_active_out      <= 1'b0;
			host_dual_strobe_out        <= 1'b0;
			host_ack_seen_out           <= 1'b0;
			host_receive_request_out    <= 1'b0;
			host_receive_request_oe_out <= 1'b0;
		end
		else if (ce_in)
		begin
			host_selected_out <= host_port_en_in &&
			    (!host_cfg_in.sel_a_n || !host_cfg_in.sel_b_n);
			host_width8_out <= host_port_en_in && host_cfg_in.width8;
			host_strobe_active_out <= host_port_en_in &&
			    (host_strobe_in == host_cfg_in.strobe_pol);
			host_dual_strobe_out <= host_port_en_in &&
			    host_cfg_in.dual_strobe;
			host_ack_seen_out <= host_port_en_in && !host_cfg_in.double_req &&
			    (host_acknowledge_in == host_cfg_in.ack_pol);
			host_receive_request_out <= host_cfg_in.rrq_pol ~^ rx_request_in;
			host_receive_request_oe_out <= host_port_en_in &&
			    host_cfg_in.double_req &&
			    (!host_cfg_in.rrq_open_drain ||
			     (rx_request_in ^ host_cfg_in.rrq_pol));
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	a_grant_onehot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$onehot0(ext_bus_grant_out) && $onehot0(ext_data_bus_grant_out))
		else $error("more than one grant");
	a_parity_odd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		^{bus_out.data[7:0], bus_out.parity[0]} == 1'b1)
		else $error("lane 0 parity not odd");
	a_parity_all: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		odd_par(bus_out.data) == bus_out.parity)
		else $error("lane parity mismatch");
	a_top_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && !bus_only_mode_in && $stable(bus_only_mode_in) |=>
		data_oe_out[63:61] == 3'h0)
		else $error("top lines driven outside bus-only");
	a_host_narrow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && host_port_en_in && $stable(host_port_en_in) |=>
		data_oe_out[63:32] == 32'h0)
		else $error("upper lines driven with host port");
	a_grant_req: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ext_bus_grant_out[1] |-> $past(ext_bus_request_in[1]))
		else $error("grant without request");
	a_busy_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && state == SBLP_WRITE && xfer_ack_in |=>
		!data_tenure_busy_out && data_tenure_busy_oe_out)
		else $error("busy not released after ack");
	a_read_sample: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state == SBLP_READ |-> ##1 data_oe_out == '0)
		else $error("device drove data in read");

endmodule : sblp_top

// [hw/sblp_pkg.sv]
package sblp_pkg;

	// ****************************************************
	// Bus geometry
	// ****************************************************
	localparam int DATA_W       = 64;
	localparam int LANES        = 8;
	localparam int BYTE_W       = 8;
	localparam int NARROW_W     = 32;
	localparam int TOP_BITS_LSB = 61;
	localparam int TOP_BITS_N   = 3;
	localparam int IRQ_N        = 8;
	localparam int REQ_N        = 2;
	localparam int FIFO_DEPTH   = 16;

	// ****************************************************
	// Carriers
	// ****************************************************
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [LANES-1:0]  parity;
	} sblp_beat_t;

	typedef struct packed {
		logic sel_a_n;
		logic sel_b_n;
		logic width8;
		logic strobe_pol;
		logic dual_strobe;
		logic double_req;
		logic ack_pol;
		logic rrq_pol;
		logic rrq_open_drain;
	} sblp_host_cfg_t;

	typedef enum logic [1:0] {
		SBLP_IDLE,
		SBLP_WRITE,
		SBLP_READ,
		SBLP_EXT
	} sblp_state_t;

	localparam logic [LANES-1:0] PAR_NONE = 8'h00;

endpackage : sblp_pkg

// [hw/sblp_fifo.sv]
`timescale 1ns/1ps
module sblp_fifo
#(
	parameter int WIDTH = 72,
	parameter int DEPTH = 16
)
(
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             ce_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_out  = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_ff @(posedge clk_in)
	begin
		if (ce_in && push)
			mem[wr_ptr] <= in_data_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (ce_in)
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : sblp_fifo

// [tb/sblp_slave_model.sv]
`timescale 1ns/1ps
module sblp_slave_model
	import sblp_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	// Device side view
	input  wire logic              busy_in,
	input  wire logic [DATA_W-1:0] oe_in,
	input  wire logic [1:0]        lat_in,
	input  wire logic [DATA_W-1:0] rd_word_in,
	input  wire logic [LANES-1:0]  bad_in,
	// Slave drive
	output sblp_beat_t             beat_out,
	output logic                   ack_out
);
	logic [3:0]       cnt;
	logic [LANES-1:0] par;

	// ****************************************************
	// Acknowledge, one cycle wide, lat+1 cycles into tenure
	// ****************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || !busy_in)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
		ack_out <= rst_n_in && busy_in && cnt == {2'h0, lat_in};
	end

	// ****************************************************
	// Read data with odd parity per lane except lanes set in bad_in; released bus toggles
	// ****************************************************
	always_comb
		for (int i = 0; i < LANES; i++)
			par[i] = ~^rd_word_in[8*i+:8];
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			beat_out <= '0;
		else if (busy_in && oe_in == '0)
			beat_out <= {rd_word_in, par ^ bad_in};
		else
			beat_out <= ~beat_out;
	end
endmodule : sblp_slave_model

// [tb/sblp_top_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
	$display("wrong value at %0t got %h exp %h", $time, a, b); end end
module sblp_top_tb_top;
	import sblp_pkg::*;
	logic                 clk_in = 0, rst_n_in = 0, hp = 0, bo = 1;
	logic                 wr_valid = 0, wr_ready, rd_start = 0, rd_valid;
	logic                 perr, ack, ext_busy = 0, busy_out, busy_oe;
	logic                 hsel, hw8, hstr, hds, hstrobe = 0, host_acknowledge = 0;
	logic                 host_acknowledge_seen, rxr = 0, host_receive_request, host_receive_request_oe;
	logic [DATA_W-1:0]    wr_data = '0, rd_data, data_oe, msk = '1, w;
	logic [DATA_W-1:0]    rd_word = '0;
	logic [LANES-1:0]     par_oe, lcm = 8'hff, bad = 8'h00;
	logic [REQ_N-1:0]     req = '0, gnt, dgnt;
	logic [IRQ_N-1:0]     irq = '1, core_irq;
	logic [1:0]           lat = 2'h1;
	logic [31:0]          seed = 32'd60182;
	sblp_host_cfg_t       cfg = '1;
	sblp_beat_t           bus_in, bus_out, beat;
	logic [DATA_W-1:0]    exp_q[$];
	int                   fails = 0, checks_done = 0, cyc = 0, i, m;

	always #2.5 clk_in = ~clk_in;
	assign bus_in = {(bus_out.data & data_oe) | (beat.data & ~data_oe),
		(bus_out.parity & par_oe) | (beat.parity & ~par_oe)};

	sblp_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
		.host_port_en_in(hp), .bus_only_mode_in(bo), .host_cfg_in(cfg),
		.wr_valid_in(wr_valid), .wr_ready_out(wr_ready),
		.wr_data_in(wr_data), .rd_start_in(rd_start),
		.rd_valid_out(rd_valid), .rd_data_out(rd_data),
		.parity_err_out(perr), .bus_in(bus_in), .bus_out(bus_out),
		.data_oe_out(data_oe), .parity_oe_out(par_oe), .xfer_ack_in(ack),
		.data_tenure_busy_in(ext_busy), .data_tenure_busy_out(busy_out),
		.data_tenure_busy_oe_out(busy_oe), .ext_bus_request_in(req),
		.ext_bus_grant_out(gnt), .ext_data_bus_grant_out(dgnt),
		.ext_interrupt_request_line_in(irq), .core_irq_out(core_irq),
		.host_selected_out(hsel), .host_width8_out(hw8),
		.host_strobe_active_out(hstr), .host_dual_strobe_out(hds),
		.host_strobe_in(hstrobe), .host_acknowledge_in(host_acknowledge),
		.host_ack_seen_out(host_acknowledge_seen), .rx_request_in(rxr),
		.host_receive_request_out(host_receive_request),
		.host_receive_request_oe_out(host_receive_request_oe));

	sblp_slave_model slave_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.busy_in(busy_out & busy_oe), .oe_in(data_oe), .lat_in(lat),
		.rd_word_in(rd_word), .bad_in(bad), .beat_out(beat),
		.ack_out(ack));

	// ****************************************************
	// Helpers
	// ****************************************************
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task tick();
		@(posedge clk_in);
		#1;
	endtask : tick

	// Valid stays up between calls so no edge sees it drop and rise
	task push(input logic [DATA_W-1:0] d);
		wr_valid = 1'b1;
		wr_data = d;
		@(posedge clk_in);
		while (wr_ready !== 1'b1)
			@(posedge clk_in);
		exp_q.push_back(d);
		#1;
	endtask : push

	task drain();
		int n;
		n = 0;
		while ((exp_q.size() != 0 || busy_oe !== 1'b0) && n < 400)
		begin
			tick();
			n++;
		end
		`CHK(exp_q.size(), 0)
	endtask : drain

	task rd(input logic [DATA_W-1:0] d, input logic [LANES-1:0] b);
		int n;
		rd_word = d;
		bad = b;
		rd_start = 1'b1;
		for (n = 0; n < 50 && busy_out !== 1'b1; n++)
			tick();
		rd_start = 1'b0;
		for (n = 0; n < 50 && rd_valid !== 1'b1; n++)
			tick();
		`CHK(rd_data, d & msk)
		`CHK(perr, b != 8'h00)
		tick();
	endtask : rd

	task test_done();
		if (fails == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// ****************************************************
	// Write beat monitor against the queue model
	// ****************************************************
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			fails++;
			test_done();
		end
		if (rst_n_in && ack === 1'b1 && data_oe != '0)
		begin
			w = exp_q.pop_front();
			`CHK(data_oe, msk)
			`CHK(bus_out.data & msk, w & msk)
			`CHK(par_oe & lcm, lcm)
			for (int k = 0; k < LANES; k++)
				if (lcm[k])
					`CHK(^{bus_out.parity[k], bus_out.data[8*k+:8]}, 1'b1)
		end
	end

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial
	begin
		repeat (10) tick();
		rst_n_in = 1'b1;
		tick();
		`CHK({wr_ready, gnt, dgnt, data_oe, core_irq}, {1'b1, 76'h0})
		for (m = 0; m < 3; m++)
		begin
			bo = m == 0;
			hp = m == 2;
			msk = m == 0 ? '1 : m == 1 ? 64'h1fffffffffffffff : 64'hffffffff;
			lcm = m == 2 ? 8'h0f : 8'hff;
			repeat (4) push({rnd(), rnd()});
			wr_valid = 1'b0;
			drain();
			rd({rnd(), rnd()}, 8'h00);
			rd({rnd(), rnd()}, 8'h01 << (rnd() % 4));
		end
		// Busy from outside holds off tenures while the buffer fills
		ext_busy = 1'b1;
		for (i = 0; i < FIFO_DEPTH; i++)
			push({rnd(), rnd()});
		wr_valid = 1'b0;
		tick();
		`CHK(wr_ready, 1'b0)
		`CHK({data_oe, busy_out}, 65'h0)
		lat = 2'h3;
		ext_busy = 1'b0;
		drain();
		// Arbitration, a wins over b
		req = 2'b11;
		repeat (2) tick();
		`CHK({gnt, dgnt}, 4'b0101)
		req = 2'b10;
		rd_start = 1'b1;
		repeat (4) tick();
		`CHK({gnt, dgnt}, 4'b1010)
		`CHK(busy_out, 1'b0)
		rd_start = 1'b0;
		req = 2'b00;
		repeat (2) tick();
		`CHK({gnt, dgnt}, 4'b0000)
		for (i = 0; i < 24; i++)
		begin
			irq = rnd();
			{hp, hstrobe, host_acknowledge, rxr} = rnd();
			cfg = rnd();
			repeat (2) tick();
			`CHK(core_irq, ~irq)
			`CHK(hsel, hp & (~cfg.sel_a_n | ~cfg.sel_b_n))
			`CHK(hw8, hp & cfg.width8)
			`CHK(hstr, hp & (hstrobe ~^ cfg.strobe_pol))
			`CHK(hds, hp & cfg.dual_strobe)
			`CHK(host_acknowledge_seen, hp & ~cfg.double_req & (host_acknowledge ~^ cfg.ack_pol))
			`CHK(host_receive_request_oe, hp & cfg.double_req & (~cfg.rrq_open_drain
				| ~(rxr ~^ cfg.rrq_pol)))
			if (host_receive_request_oe === 1'b1)
				`CHK(host_receive_request, rxr ~^ cfg.rrq_pol)
		end
		test_done();
	end
endmodule : sblp_top_tb_top
